/* File: src/ccu_capture.v */
// Purpose: image sensor capture front end with preview and codec word outputs
// Assumes: pixel clock, syncs and data are asynchronous pins sampled by mclk
// Notes: scaler and colour conversion are outside this block
`timescale 1ns/1ps
`include "ccu_defines.vh"
module ccu_capture (
    input wire mclk, // 100 MHz system clock
    input wire reset_n, // async reset, active low
    input wire [`CCU_AW-1:0] reg_addr, // register byte address
    input wire [31:0] reg_wdata, // register write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [31:0] reg_rdata, // read data, cycle after strobe
    input wire sensor_pixel_clock_in, // pixel clock from sensor
    input wire frame_sync_in, // vertical sync pin
    input wire line_sync_in, // horizontal sync pin
    input wire [`CCU_PIXW-1:0] sensor_pixel_bus, // pixel data pins
    output reg sensor_master_clock_out, // master clock to sensor
    output wire [`CCU_DW-1:0] pv_data, // preview path word
    output wire pv_valid, // preview word valid
    input wire pv_ready, // preview consumer takes word
    output wire [`CCU_DW-1:0] cd_data, // codec path word
    output wire cd_valid, // codec word valid
    input wire cd_ready, // codec consumer takes word
    output reg capture_busy // a kept frame is in progress
);
    reg [31:0] ctl1_r;
    reg [31:0] ctl2_r;
    reg [31:0] ctl3_r;
    reg [`CCU_NFLAG-1:0] flag_r;
    reg [`CCU_SYNCW-1:0] smp1_r;
    reg [`CCU_SYNCW-1:0] smp2_r;
    reg pck3_r;
    reg [7:0] div_cnt_r;
    reg vs_prev_r, hs_prev_r, line_r, frame_r, take_r;
    reg [23:0] hist_r;
    reg [11:0] gap_cnt_r;
    reg [10:0] pix_cnt_r, line_cnt_r, cap_lines_r;
    reg [2:0] skip_cnt_r;
    reg [1:0] ph_r;
    reg [23:0] bytes_r;
    reg half_ph_r;
    reg [15:0] hw_r;
    reg word_v_r;
    reg [`CCU_DW-1:0] word_r;
    reg [15:0] half16;
    reg [`CCU_DW-1:0] word_nxt;
    reg [1:0] ph_max;
    wire [1:0] path_wr;
    wire [1:0] path_rdy;
    wire [1:0] path_vld;
    wire [1:0] path_ovr;
    wire [2*`CCU_DW-1:0] path_dout;
    wire [`CCU_NFLAG-1:0] ev;

    // bit reversal of a byte, used for the swapped RGB input layouts
    function [7:0] ccu_rev8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                ccu_rev8[i] = v[7-i];
            end
        end
    endfunction

    // control fields
    wire en = ctl1_r[`CCU_B_EN];
    wire emb = ctl1_r[`CCU_B_EMB];
    wire gray = ctl1_r[`CCU_B_GRAY];
    wire gpack = ctl1_r[`CCU_B_GPACK];
    wire swap = ctl1_r[`CCU_B_SWAP];
    wire [1:0] fmt = ctl1_r[`CCU_F_FMT];
    wire [1:0] yord = ctl1_r[`CCU_F_YORD];
    wire [1:0] rord = ctl1_r[`CCU_F_RORD];
    wire [2:0] skip = ctl1_r[`CCU_F_SKIP];
    wire [10:0] wid = ctl2_r[`CCU_F_WID];
    wire [10:0] hgt = ctl2_r[`CCU_F_HGT];
    wire [7:0] frame_start_line_delay = ctl3_r[`CCU_F_SFD];
    wire [7:0] line_start_pixel_delay = ctl3_r[`CCU_F_SLD];
    wire [7:0] div = ctl3_r[`CCU_F_DIV];
    wire ycc = !gray && (fmt == `CCU_FMT_YCC);

    // two flops on every pin; pclk's third flop only feeds the edge finder
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            smp1_r <= {`CCU_SYNCW{1'b0}};
            smp2_r <= {`CCU_SYNCW{1'b0}};
            pck3_r <= 1'b0;
        end else begin
            smp1_r <= {sensor_pixel_clock_in, frame_sync_in, line_sync_in, sensor_pixel_bus};
            smp2_r <= smp1_r;
            pck3_r <= smp2_r[`CCU_S_PCK];
        end
    end

    // data sit beside pclk in stage two, so the edge and its byte line up
    wire pck2 = smp2_r[`CCU_S_PCK];
    wire act_edge = ctl1_r[`CCU_B_PEDGE] ? (~pck2 & pck3_r) : (pck2 & ~pck3_r);
    wire [`CCU_PIXW-1:0] pix = smp2_r[`CCU_PIXW-1:0];
    wire [7:0] d8 = pix[7:0];
    wire vs_act = smp2_r[`CCU_S_VS] ^ ctl1_r[`CCU_B_VPOL];
    wire hs_act = smp2_r[`CCU_S_HS] ^ ctl1_r[`CCU_B_HPOL];

    // delimiter decode: preamble then status byte
    wire pre_hit = (hist_r == `CCU_PRE);
    wire sav = emb && pre_hit && (d8 == `CCU_SAV);
    wire eav = emb && pre_hit && (d8 == `CCU_EAV);

    // frame and line events, one per pin scheme
    wire ls_e = emb ? sav : (hs_act & ~hs_prev_r);
    wire fs_e = emb ? (sav && (gap_cnt_r > {1'b0, wid})) : (vs_act & ~vs_prev_r);
    wire le_e = emb ? (eav & line_r) : (~hs_act & hs_prev_r);
    wire [10:0] pidx = ls_e ? {11{1'b0}} : pix_cnt_r;
    wire line_ok = emb || (line_cnt_r >= {3'b000, frame_start_line_delay});
    // code bytes and blanking never reach the assembler
    wire win_emb = line_r && !pre_hit && (d8 != `CCU_BYTE_FF) && (d8 != `CCU_BYTE_00);
    wire win_pin = hs_act && line_ok && (pidx >= {3'b000, line_start_pixel_delay});
    wire take = frame_r && take_r && en;
    wire byte_v = act_edge && take && (emb ? win_emb : win_pin);
    wire last_line = le_e && take && line_ok && ((cap_lines_r + 11'h001) == hgt);
    wire fd_e = act_edge && last_line;

    // frame, line and skip tracking on each active pixel edge
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vs_prev_r <= 1'b0;
            hs_prev_r <= 1'b0;
            hist_r <= 24'h000000;
            gap_cnt_r <= `CCU_GAP_MAX;
            line_r <= 1'b0;
            pix_cnt_r <= {11{1'b0}};
            line_cnt_r <= {11{1'b0}};
            cap_lines_r <= {11{1'b0}};
            frame_r <= 1'b0;
            take_r <= 1'b0;
            skip_cnt_r <= 3'h0;
        end else if (act_edge) begin
            vs_prev_r <= vs_act;
            hs_prev_r <= hs_act;
            hist_r <= {hist_r[15:0], d8};
            if (eav) begin
                gap_cnt_r <= 12'h000;
            end else if (gap_cnt_r != `CCU_GAP_MAX) begin
                gap_cnt_r <= gap_cnt_r + 12'h001;
            end
            if (sav) begin
                line_r <= 1'b1;
            end else if (eav) begin
                line_r <= 1'b0;
            end
            pix_cnt_r <= pidx + 11'h001;
            if (fs_e) begin
                frame_r <= 1'b1;
                take_r <= (skip_cnt_r == 3'h0);
                skip_cnt_r <= (skip_cnt_r >= skip) ? 3'h0 : skip_cnt_r + 3'h1;
                line_cnt_r <= {11{1'b0}};
                cap_lines_r <= {11{1'b0}};
            end else begin
                if (le_e) begin
                    line_cnt_r <= line_cnt_r + 11'h001;
                end
                if (le_e && take && line_ok) begin
                    cap_lines_r <= cap_lines_r + 11'h001;
                end
                // pin mode also closes the frame when the vertical sync drops
                if (last_line || (!emb && !vs_act && vs_prev_r)) begin
                    frame_r <= 1'b0;
                end
            end
        end
    end

    // input byte, bit reversed for the swapped RGB layouts
    wire [7:0] din = (swap && !gray && !ycc) ? ccu_rev8(d8) : d8;
    wire [7:0] x0 = bytes_r[7:0];

    // component decode per input format and order
    always @* begin
        half16 = 16'h0000;
        word_nxt = {`CCU_DW{1'b0}};
        ph_max = `CCU_PH_GRAY;
        if (gray) begin
            ph_max = `CCU_PH_GRAY;
            half16 = {pix, 4'h0};
        end else if (fmt == `CCU_FMT_888) begin
            ph_max = `CCU_PH_888;
            half16 = {1'b0, bytes_r[15:11], x0[7:3], din[7:3]};
        end else if (fmt == `CCU_FMT_565) begin
            ph_max = `CCU_PH_565;
            if (rord == `CCU_RGB_M2) begin
                half16 = {1'b0, x0[4:0], din[2:0], x0[7:6], din[7:3]};
            end else begin
                half16 = {1'b0, x0[7:3], x0[2:0], din[7:6], din[4:0]};
            end
        end else begin
            ph_max = `CCU_PH_YCC;
        end
        // words leave in Cb,Y0,Cr,Y1 order whatever the sensor sends
        if (ycc) begin
            case (yord)
                `CCU_Y_CB: word_nxt = {bytes_r, din};
                `CCU_Y_CR: word_nxt = {x0, bytes_r[15:8], bytes_r[23:16], din};
                `CCU_Y_YCB: word_nxt = {bytes_r[15:8], bytes_r[23:16], din, x0};
                `CCU_Y_YCR: word_nxt = {din, bytes_r[23:16], bytes_r[15:8], x0};
                default: word_nxt = {bytes_r, din};
            endcase
        end else if (gray && gpack) begin
            word_nxt = {half16, 16'h0000};
        end else begin
            word_nxt = {hw_r, half16};
        end
    end

    // a line start edge may carry the first byte, so it counts as phase zero
    wire [1:0] ph_cur = ls_e ? 2'h0 : ph_r;
    wire half_cur = fs_e ? 1'b0 : half_ph_r;
    wire px_done = byte_v && (ph_cur == ph_max);
    wire one_per_word = ycc || (gray && gpack);
    wire emit = px_done && (one_per_word || half_cur);

    // byte phase and half word pairing; phase realigned at every line start, pairing at every frame start
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ph_r <= 2'h0;
            bytes_r <= 24'h000000;
            half_ph_r <= 1'b0;
            hw_r <= 16'h0000;
            word_v_r <= 1'b0;
            word_r <= {`CCU_DW{1'b0}};
        end else begin
            word_v_r <= emit;
            if (emit) begin
                word_r <= word_nxt;
            end
            if (byte_v) begin
                ph_r <= (ph_cur == ph_max) ? 2'h0 : ph_cur + 2'h1;
                bytes_r <= {bytes_r[15:0], din};
                if (px_done && !one_per_word) begin
                    half_ph_r <= ~half_cur;
                    if (!half_cur) begin
                        hw_r <= half16;
                    end
                end else begin
                    half_ph_r <= half_cur;
                end
            end else if (act_edge) begin
                if (ls_e) begin
                    ph_r <= 2'h0;
                end
                if (fs_e) begin
                    half_ph_r <= 1'b0;
                end
            end
        end
    end

    // preview always, codec only when enabled and not grayscale
    assign path_wr[0] = word_v_r;
    assign path_wr[1] = word_v_r && ctl1_r[`CCU_B_CODEC] && !gray;
    assign path_rdy = {cd_ready, pv_ready};

    // one FIFO per path; a full FIFO drops the word and flags overrun
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_path
            reg [`CCU_FAW-1:0] wp_r;
            reg [`CCU_FAW-1:0] rp_r;
            reg [`CCU_FAW:0] cnt_r;
            reg vld_r;
            wire full = (cnt_r == `CCU_FDEPTH);
            wire push = path_wr[gi] && !full;
            wire pop = (cnt_r != {(`CCU_FAW+1){1'b0}}) && (!vld_r || path_rdy[gi]);
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    wp_r <= {`CCU_FAW{1'b0}};
                    rp_r <= {`CCU_FAW{1'b0}};
                    cnt_r <= {(`CCU_FAW+1){1'b0}};
                    vld_r <= 1'b0;
                end else begin
                    if (push) begin
                        wp_r <= wp_r + 1'b1;
                    end
                    if (pop) begin
                        rp_r <= rp_r + 1'b1;
                    end
                    cnt_r <= cnt_r + {{`CCU_FAW{1'b0}}, push} - {{`CCU_FAW{1'b0}}, pop};
                    vld_r <= pop | (vld_r & ~path_rdy[gi]);
                end
            end
            assign path_vld[gi] = vld_r;
            assign path_ovr[gi] = path_wr[gi] && full;
            ccu_mem u_mem (
                .mclk(mclk),
                .reset_n(reset_n),
                .wr_en(push),
                .wr_addr(wp_r),
                .wr_data(word_r),
                .rd_en(pop),
                .rd_addr(rp_r),
                .rd_data(path_dout[gi*`CCU_DW +: `CCU_DW])
            );
        end
    endgenerate

    assign pv_data = path_dout[`CCU_DW-1:0];
    assign cd_data = path_dout[2*`CCU_DW-1:`CCU_DW];
    assign pv_valid = path_vld[0];
    assign cd_valid = path_vld[1];

    // events feeding the sticky flags
    assign ev[`CCU_FL_FS] = act_edge && fs_e && en;
    assign ev[`CCU_FL_FD] = fd_e;
    assign ev[`CCU_FL_SAV] = act_edge && sav && en;
    assign ev[`CCU_FL_EAV] = act_edge && eav && en;
    assign ev[`CCU_FL_POVR] = path_ovr[0];
    assign ev[`CCU_FL_COVR] = path_ovr[1];

    wire wr_stat = reg_wr && (reg_addr == `CCU_A_STAT);
    wire [`CCU_NFLAG-1:0] clr = wr_stat ? reg_wdata[`CCU_NFLAG-1:0] : {`CCU_NFLAG{1'b0}};
    reg [31:0] stat_w;
    reg [31:0] rd_mux;

    // status word and read decode
    always @* begin
        stat_w = 32'h00000000;
        stat_w[`CCU_NFLAG-1:0] = flag_r;
        stat_w[`CCU_B_BUSY] = take;
        case (reg_addr)
            `CCU_A_CTL1: rd_mux = ctl1_r;
            `CCU_A_CTL2: rd_mux = ctl2_r;
            `CCU_A_CTL3: rd_mux = ctl3_r;
            `CCU_A_STAT: rd_mux = stat_w;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // register writes; a flag set in the clearing cycle survives
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctl1_r <= `CCU_CTL1_RST;
            ctl2_r <= `CCU_CTL2_RST;
            ctl3_r <= `CCU_CTL3_RST;
            flag_r <= {`CCU_NFLAG{1'b0}};
            reg_rdata <= 32'h00000000;
            capture_busy <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == `CCU_A_CTL1)) begin
                ctl1_r <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `CCU_A_CTL2)) begin
                ctl2_r <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `CCU_A_CTL3)) begin
                ctl3_r <= reg_wdata;
            end
            flag_r <= ev | (flag_r & ~clr);
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
            capture_busy <= take;
        end
    end

    // master clock: half period of div mclk cycles, a zero divisor acts as one
    wire [7:0] div_top = (div == 8'h00) ? 8'h00 : div - 8'h01;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_r <= 8'h00;
            sensor_master_clock_out <= 1'b0;
        end else if (div_cnt_r >= div_top) begin
            div_cnt_r <= 8'h00;
            sensor_master_clock_out <= ~sensor_master_clock_out;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
        end
    end
endmodule

/* File: src/ccu_defines.vh */
// Purpose: shared constants for the camera capture unit front end
// Assumes: 100 MHz mclk, sensor pixel clock well below mclk/2
// Notes: register offsets are byte addresses on the plain register port
//
// Operation
// - frames found either by sync pins or by embedded delimiter codes
// - sync pulse active level is programmable
// - pixel input bus up to 12 bits wide
// - master clock driven to sensor; data sampled on the sensor pixel clock
// - flag raised at frame start and at end of a complete frame
// - in delimiter mode, with capture enabled, a flag is raised on every start or end code
// - 8-bit colour input may be YCbCr 4:2:2, RGB 8:8:8 or RGB 5:6:5
// - codec path gets the colour stream only when codec enable is one
// - grayscale 12-bit samples stored raw, one or two per word by packing bit
// - codec path is unavailable while grayscale is selected
// - capture every frame or one out of N, N from 2 to 8
// - pin mode: skip programmed blank lines, then programmed pixel clocks
// - delimiter mode works on an 8-bit data interface
// - start code FF000080, end code FF00009D
// - delimiter mode captures only data between codes, blanking dropped
// - four selectable YCbCr byte orders for a pixel pair
// - RGB order 00 no swap: 8:8:8 bytes R,G,B; 5:6:5 split as listed
// - preview and codec paths buffer pixel data in FIFOs
// - preview path emits the same captured words as the codec path, no RGB conversion
// - path FIFOs carry formatted pixels toward the system side
`ifndef CCU_DEFINES_VH
`define CCU_DEFINES_VH
`define CCU_AW 4
`define CCU_A_CTL1 4'h0
`define CCU_A_CTL2 4'h4
`define CCU_A_CTL3 4'h8
`define CCU_A_STAT 4'hC
`define CCU_CTL1_RST 32'h00000000
`define CCU_CTL2_RST 32'h00000000
`define CCU_CTL3_RST 32'h00010000
`define CCU_B_EN 0
`define CCU_B_EMB 1
`define CCU_B_VPOL 2
`define CCU_B_HPOL 3
`define CCU_B_PEDGE 4
`define CCU_B_CODEC 5
`define CCU_B_GRAY 6
`define CCU_B_GPACK 7
`define CCU_F_SKIP 10:8
`define CCU_F_YORD 12:11
`define CCU_F_RORD 14:13
`define CCU_B_SWAP 15
`define CCU_F_FMT 17:16
`define CCU_F_WID 10:0
`define CCU_F_HGT 21:11
`define CCU_F_SFD 7:0
`define CCU_F_SLD 15:8
`define CCU_F_DIV 23:16
`define CCU_NFLAG 6
`define CCU_FL_FS 0
`define CCU_FL_FD 1
`define CCU_FL_SAV 2
`define CCU_FL_EAV 3
`define CCU_FL_POVR 4
`define CCU_FL_COVR 5
`define CCU_B_BUSY 8
`define CCU_PRE 24'hFF0000
`define CCU_SAV 8'h80
`define CCU_EAV 8'h9D
`define CCU_BYTE_FF 8'hFF
`define CCU_BYTE_00 8'h00
`define CCU_FMT_YCC 2'h0
`define CCU_FMT_888 2'h1
`define CCU_FMT_565 2'h2
`define CCU_RGB_M2 2'h2
`define CCU_Y_CB 2'h0
`define CCU_Y_CR 2'h1
`define CCU_Y_YCB 2'h2
`define CCU_Y_YCR 2'h3
`define CCU_PH_YCC 2'h3
`define CCU_PH_888 2'h2
`define CCU_PH_565 2'h1
`define CCU_PH_GRAY 2'h0
`define CCU_DW 32
`define CCU_FAW 2
`define CCU_FDEPTH 3'h4
`define CCU_PIXW 12
`define CCU_SYNCW 15
`define CCU_S_PCK 14
`define CCU_S_VS 13
`define CCU_S_HS 12
`define CCU_GAP_MAX 12'hFFF
`endif

/* File: src/ccu_mem.v */
// Purpose: small word store behind each path FIFO
// Assumes: one write and one read port on mclk
// Notes: read data come out of a register and hold between reads
`timescale 1ns/1ps
`include "ccu_defines.vh"
module ccu_mem (
    input wire mclk, // system clock
    input wire reset_n, // async reset, active low
    input wire wr_en, // write this word
    input wire [`CCU_FAW-1:0] wr_addr, // write slot
    input wire [`CCU_DW-1:0] wr_data, // word written
    input wire rd_en, // read a slot into rd_data
    input wire [`CCU_FAW-1:0] rd_addr, // read slot
    output reg [`CCU_DW-1:0] rd_data // registered read word
);
    reg [`CCU_DW-1:0] mem_r [0:(1<<`CCU_FAW)-1];

    // array has no reset, it is only read after being written
    always @(posedge mclk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // registered read port
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= {`CCU_DW{1'b0}};
        end else if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule

/* File: testbench/ccu_capture_sva.sv */
// Purpose: port-level checks on the capture front end
// Assumes: master clock divisor left at its reset value
// Notes: keeps a shadow of the first control word to know the path modes
`timescale 1ns/1ps
`include "ccu_defines.vh"
module ccu_capture_sva (
    input wire mclk, // system clock
    input wire reset_n, // async reset, active low
    input wire [`CCU_AW-1:0] reg_addr, // register address
    input wire [31:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [31:0] reg_rdata, // read data
    input wire sensor_master_clock_out, // clock to sensor
    input wire [`CCU_DW-1:0] pv_data, // preview word
    input wire pv_valid, // preview valid
    input wire pv_ready, // preview ready
    input wire [`CCU_DW-1:0] cd_data, // codec word
    input wire cd_valid, // codec valid
    input wire cd_ready // codec ready
);
    reg [31:0] ctl1_r;
    // shadow follows every write so mode-dependent checks track software
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            ctl1_r <= 32'h00000000;
        else if (reg_wr && reg_addr == `CCU_A_CTL1)
            ctl1_r <= reg_wdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data without a read strobe");
    chk_unmapped_rd: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h00000000)
        else $error("unmapped read returned data");
    chk_stat_rsv: assert property (reg_rd && reg_addr == `CCU_A_STAT |=> reg_rdata[31:9] == 23'h0 && reg_rdata[7:6] == 2'h0)
        else $error("reserved status bits set");
    chk_wr_readback: assert property (reg_wr && reg_addr == `CCU_A_CTL2 ##2 reg_rd && reg_addr == `CCU_A_CTL2
        |=> reg_rdata[21:0] == $past(reg_wdata[21:0], 3))
        else $error("size register readback differs");
    chk_pv_hold: assert property (pv_valid && !pv_ready |=> pv_valid && $stable(pv_data))
        else $error("preview word dropped while stalled");
    chk_cd_hold: assert property (cd_valid && !cd_ready |=> cd_valid && $stable(cd_data))
        else $error("codec word dropped while stalled");
    chk_codec_gate: assert property ((!ctl1_r[`CCU_B_CODEC] || ctl1_r[`CCU_B_GRAY]) && !cd_valid |=> !cd_valid)
        else $error("codec word while codec path off");
    chk_mck_toggle: assert property (1'b1 |=> sensor_master_clock_out != $past(sensor_master_clock_out))
        else $error("sensor clock missed a toggle");
endmodule
bind ccu_capture ccu_capture_sva ccu_capture_sva_i (.*);

/* File: testbench/ccu_capture_tb_top.sv */
// Purpose: self-checking bench for the capture front end
// Assumes: one-line frames, width 4, height 1
// Notes: consumers stall at random; accepted words are queued and compared
`timescale 1ns/1ps
`include "ccu_defines.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module ccu_capture_tb_top;
    logic mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pv_ready = 1'b0, cd_ready = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, pv_data, cd_data, q;
    logic sck, vsy, hsy, mck, pv_valid, cd_valid, busy, bz;
    logic [11:0] dat;
    logic [31:0] pvq[$], cdq[$];
    logic [11:0] px[$];
    int n_errors = 0, comparisons = 0, cyc = 0;
    int nb[10] = '{4, 4, 4, 4, 6, 4, 2, 1, 4, 6}, nbz = 0;
    always #5 mclk = ~mclk;
    ccu_capture ccu_capture_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sensor_pixel_clock_in(sck),
        .frame_sync_in(vsy), .line_sync_in(hsy), .sensor_pixel_bus(dat), .sensor_master_clock_out(mck),
        .pv_data(pv_data), .pv_valid(pv_valid), .pv_ready(pv_ready), .cd_data(cd_data),
        .cd_valid(cd_valid), .cd_ready(cd_ready), .capture_busy(busy));
    ccu_sensor_model ccu_sensor_model_i (.pck(sck), .vsy(vsy), .hsy(hsy), .dat(dat));
    // random stalls on both paths; a hang ends in the report
    always @(posedge mclk) begin
        pv_ready <= 1'($urandom);
        cd_ready <= 1'($urandom);
        if (pv_valid && pv_ready) pvq.push_back(pv_data);
        if (cd_valid && cd_ready) cdq.push_back(cd_data);
        // kept frames counted by rises of the busy output
        bz <= busy;
        if (busy && !bz) nbz++;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            complete_run;
        end
    end
    task complete_run;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one register cycle; a gap cycle follows so strobes never merge
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] m, e, input string n);
        acc(1'b0, a, 32'h0);
        `CHK(n, e, q & m)
    endtask
    task frame(input int n);
        px = {};
        for (int i = 0; i < n; i++) px.push_back(12'($urandom));
        ccu_sensor_model_i.frame(px);
        repeat (40) @(posedge mclk);
    endtask
    function automatic logic [11:0] rv(input logic [11:0] v);
        for (int i = 0; i < 8; i++) rv[i] = v[7 - i];
        rv[11:8] = 4'h0;
    endfunction
    // word per case: YCbCr orders 0..3, 888, 565, gray two and one, 565 mode 2, swapped 888
    function automatic logic [31:0] expw(input int k, input logic [11:0] p[$]);
        case (k)
            0: return {p[0][7:0], p[1][7:0], p[2][7:0], p[3][7:0]};
            1: return {p[2][7:0], p[1][7:0], p[0][7:0], p[3][7:0]};
            2: return {p[1][7:0], p[0][7:0], p[3][7:0], p[2][7:0]};
            3: return {p[3][7:0], p[0][7:0], p[1][7:0], p[2][7:0]};
            4: return {1'b0, p[0][7:3], p[1][7:3], p[2][7:3], 1'b0, p[3][7:3], p[4][7:3], p[5][7:3]};
            5: return {1'b0, p[0][7:0], p[1][7:6], p[1][4:0], 1'b0, p[2][7:0], p[3][7:6], p[3][4:0]};
            6: return {p[0], 4'h0, p[1], 4'h0};
            8: return {1'b0, p[0][4:0], p[1][2:0], p[0][7:6], p[1][7:3],
                1'b0, p[2][4:0], p[3][2:0], p[2][7:6], p[3][7:3]};
            9: begin
                foreach (p[i]) p[i] = rv(p[i]);
                return expw(4, p);
            end
            default: return {p[0], 4'h0, 16'h0};
        endcase
    endfunction
    initial begin
        q = $urandom(32'h3F001F14);
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`CCU_A_CTL1, 32'hFFFFFFFF, 32'h0, "ctl1 reset");
        rd(`CCU_A_CTL3, 32'hFFFFFFFF, `CCU_CTL3_RST, "ctl3 reset");
        rd(`CCU_A_STAT, 32'h0000013F, 32'h0, "status reset");
        acc(1'b1, 4'h2, 32'hFFFFFFFF);
        rd(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
        acc(1'b1, `CCU_A_CTL2, 32'h00000804);
        rd(`CCU_A_CTL2, 32'h003FFFFF, 32'h00000804, "ctl2");
        // embedded codes with blanking on both sides
        px = {12'h0A5, 12'h05A, 12'h0FF, 12'h000, 12'h000, 12'h080};
        repeat (4) px.push_back(12'($urandom_range(16, 239)));
        px = {px, 12'h0FF, 12'h000, 12'h000, 12'h09D, 12'h0C3};
        acc(1'b1, `CCU_A_CTL1, 32'h00000003);
        ccu_sensor_model_i.bytes(px);
        repeat (40) @(posedge mclk);
        `CHK("delim words", 1, pvq.size())
        `CHK("delim word", expw(0, px[6:9]), pvq.pop_front())
        rd(`CCU_A_STAT, 32'h0000000D, 32'h0000000D, "delim flags");
        acc(1'b1, `CCU_A_STAT, 32'h0000003F);
        // every format, all four YCbCr orders and RGB orders 0 and 2, polarity alternating, codec on
        for (int k = 0; k < 10; k++) begin
            ccu_sensor_model_i.inv = k[0];
            acc(1'b1, `CCU_A_CTL1, 32'(32'h21 | (k % 2) * 12 | (k / 2 == 3) << 6 | (k == 7) << 7
                | (k < 4 ? k : 0) << 11 | (k == 4 || k == 9 ? 1 : k == 5 || k == 8 ? 2 : 0) << 16
                | (k == 8) << 14 | (k == 9) << 15));
            frame(nb[k]);
            `CHK("pv words", 1, pvq.size())
            `CHK("pv word", expw(k, px), pvq.pop_front())
            `CHK("cd words", k < 6 || k > 7, cdq.size())
            if (k < 6 || k > 7) `CHK("cd word", expw(k, px), cdq.pop_front())
            rd(`CCU_A_STAT, 32'h3, 32'h3, "frame flags");
            acc(1'b1, `CCU_A_STAT, 32'h0000003F);
            pvq = {};
            cdq = {};
        end
        // one of every s+1 frames kept
        ccu_sensor_model_i.inv = 1'b0;
        for (int s = 1; s < 8; s++) begin
            acc(1'b1, `CCU_A_CTL1, 32'(1 | s << 8));
            nbz = 0;
            repeat (2 * s + 2) frame(4);
            `CHK("kept frames", 2, pvq.size())
            `CHK("busy frames", 2, nbz)
            `CHK("codec idle", 0, cdq.size())
            pvq = {};
        end
        complete_run;
    end
endmodule

/* File: testbench/ccu_sensor_model.sv */
// Purpose: behavioural image sensor on the pixel pins
// Assumes: rising pixel clock edge is the active one
// Notes: clock stands still between frames; blank data inverts the last value
`timescale 1ns/1ps
module ccu_sensor_model (
    output logic pck, // pixel clock
    output logic vsy, // frame sync
    output logic hsy, // line sync
    output logic [11:0] dat // pixel data
);
    logic inv = 1'b0; // syncs active low when set
    // pins idle from time zero
    initial begin
        pck = 1'b0;
        vsy = 1'b0;
        hsy = 1'b0;
        dat = 12'h000;
    end
    // data set half a period before the edge, held half a period after
    task tick(input logic [11:0] d);
        dat = d;
        #62.5 pck = 1'b1;
        #62.5 pck = 1'b0;
    endtask
    // stale data must never pass for fresh
    task blank;
        tick(~dat);
    endtask
    // raw stream, offset so pin edges avoid mclk edges
    task bytes(input logic [11:0] q[$]);
        #2;
        foreach (q[i]) tick(q[i]);
    endtask
    // one frame of one line
    task frame(input logic [11:0] q[$]);
        vsy = inv;
        hsy = inv;
        #250 vsy = !inv;
        blank;
        hsy = !inv;
        bytes(q);
        hsy = inv;
        blank;
        vsy = inv;
        // one more edge so the sync drop is seen before the clock stops
        blank;
    endtask
endmodule
